// ==== clock_conditioner_dynamic_config.sv ====
/*
 * Dynamic configuration path of the clock conditioning circuit: 81-bit shift
 * register, update latch, static/dynamic source choice, decoded setting fields,
 * and the user jtag tile pass-through to fabric.
 * Assumes fabric logic drives the shift controls as its own tap controller and
 * that all control pins are asynchronous to mclk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module clock_conditioner_dynamic_config (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// fabric side shift port
	input wire logic sdin_i,
	input wire logic sclk_i,
	input wire logic sshift_i,
	input wire logic supdate_i,
	input wire logic mode_i,
	output logic sdout_o,
	// static flash switch settings
	input wire logic [80:0] static_config_i,
	// jtag port pins and user jtag tile fabric side
	input wire logic jtag_tck_i,
	input wire logic jtag_tms_i,
	input wire logic jtag_tdi_i,
	input wire logic jtag_trst_b_i,
	output logic jtag_tdo_o,
	output logic fabric_tck_o,
	output logic fabric_tms_o,
	output logic fabric_tdi_o,
	output logic fabric_trst_b_o,
	input wire logic fabric_tdo_i,
	// applied settings
	output logic [80:0] active_config_o,
	output logic reset_enable_o,
	output logic dynamic_select_out_c_o,
	output logic dynamic_select_out_b_o,
	output logic dynamic_select_out_a_o,
	output logic [2:0] oscillator_range_select_o,
	output logic static_select_out_c_o,
	output logic static_select_out_b_o,
	output logic static_select_out_a_o,
	output logic [4:0] delay_out_c_o,
	output logic [4:0] delay_out_b_o,
	output logic [4:0] global_delay_c_o,
	output logic [4:0] global_delay_b_o,
	output logic [4:0] global_delay_a_o,
	output logic extra_delay_select_o,
	output logic [4:0] feedback_delay_o,
	output logic [1:0] feedback_source_select_o,
	output logic [2:0] output_c_route_select_o,
	output logic [2:0] output_b_route_select_o,
	output logic [2:0] output_a_route_select_o,
	output logic [4:0] output_c_divider_o,
	output logic [4:0] output_b_divider_o,
	output logic [4:0] output_a_divider_o,
	output logic [6:0] feedback_divider_o,
	output logic [6:0] input_divider_o
);
	localparam int W = clock_conditioner_pkg::CFG_WIDTH;

	pin_sync_if sync_bus ();

	// pin vector and configuration state
	logic [clock_conditioner_pkg::PIN_COUNT-1:0] pins;
	logic [W-1:0] shift_r;
	logic [W-1:0] shift_nxt;
	logic [W-1:0] dyn_cfg_r;
	logic [W-1:0] dyn_cfg_nxt;
	logic [W-1:0] active_r;
	logic [W-1:0] active_nxt;
	// user jtag tile state
	logic jtag_tdo_r;
	logic jtag_tdo_nxt;
	logic [3:0] fabric_jtag_r;
	logic [3:0] fabric_jtag_nxt;

	// ----------------------------------------------------------------
	// pin synchronisation
	// ----------------------------------------------------------------
	// gather asynchronous pins into one vector
	always_comb begin
		pins = '0;
		pins[clock_conditioner_pkg::PIN_SDIN] = sdin_i;
		pins[clock_conditioner_pkg::PIN_SCLK] = sclk_i;
		pins[clock_conditioner_pkg::PIN_SSHIFT] = sshift_i;
		pins[clock_conditioner_pkg::PIN_SUPDATE] = supdate_i;
		pins[clock_conditioner_pkg::PIN_MODE] = mode_i;
		pins[clock_conditioner_pkg::PIN_TCK] = jtag_tck_i;
		pins[clock_conditioner_pkg::PIN_TMS] = jtag_tms_i;
		pins[clock_conditioner_pkg::PIN_TDI] = jtag_tdi_i;
		pins[clock_conditioner_pkg::PIN_TRST_B] = jtag_trst_b_i;
	end

	pin_sync u_pin_sync (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.pins_i(pins),
		.sync_o(sync_bus.producer)
	);

	// ----------------------------------------------------------------
	// shift register and update latch
	// ----------------------------------------------------------------
	// shift on sclk rise while shift enabled, latch on update rise only
	always_comb begin
		shift_nxt = shift_r;
		dyn_cfg_nxt = dyn_cfg_r;
		if (sync_bus.rise[clock_conditioner_pkg::PIN_SCLK] &&
				sync_bus.level[clock_conditioner_pkg::PIN_SSHIFT]) begin
			shift_nxt = {sync_bus.level[clock_conditioner_pkg::PIN_SDIN], shift_r[W-1:1]}; // R08 R10 R11
		end
		if (sync_bus.rise[clock_conditioner_pkg::PIN_SUPDATE]) begin
			dyn_cfg_nxt = shift_r; // R11
		end
	end

	// ----------------------------------------------------------------
	// settings source
	// ----------------------------------------------------------------
	// pick static switches or dynamic register as the applied settings
	always_comb begin
		if (sync_bus.level[clock_conditioner_pkg::PIN_MODE]) begin
			active_nxt = dyn_cfg_r; // R01 R09
		end else begin
			active_nxt = static_config_i; // R01
		end
	end

	// register configuration state
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			shift_r <= clock_conditioner_pkg::CFG_RESET;
			dyn_cfg_r <= clock_conditioner_pkg::CFG_RESET;
			active_r <= clock_conditioner_pkg::CFG_RESET;
		end else begin
			shift_r <= shift_nxt;
			dyn_cfg_r <= dyn_cfg_nxt;
			active_r <= active_nxt;
		end
	end

	// oldest bit leaves first, so fabric can read back what was shifted
	assign sdout_o = shift_r[0]; // R07

	// ----------------------------------------------------------------
	// user jtag tile
	// ----------------------------------------------------------------
	// pass jtag pins to fabric and fabric data back out, no test mode entry
	always_comb begin
		fabric_jtag_nxt = {sync_bus.level[clock_conditioner_pkg::PIN_TRST_B],
			sync_bus.level[clock_conditioner_pkg::PIN_TDI],
			sync_bus.level[clock_conditioner_pkg::PIN_TMS],
			sync_bus.level[clock_conditioner_pkg::PIN_TCK]}; // R06
		jtag_tdo_nxt = fabric_tdo_i; // R06
	end

	// register jtag tile outputs
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			fabric_jtag_r <= 4'h0;
			jtag_tdo_r <= 1'b0;
		end else begin
			fabric_jtag_r <= fabric_jtag_nxt;
			jtag_tdo_r <= jtag_tdo_nxt;
		end
	end

	// fabric side of the tile, one register behind the synchronised pins
	assign fabric_tck_o = fabric_jtag_r[0];
	assign fabric_tms_o = fabric_jtag_r[1];
	assign fabric_tdi_o = fabric_jtag_r[2];
	assign fabric_trst_b_o = fabric_jtag_r[3];
	assign jtag_tdo_o = jtag_tdo_r;

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	// control bits
	assign active_config_o = active_r;
	assign reset_enable_o = active_r[clock_conditioner_pkg::RESET_ENABLE_BIT]; // R02
	assign dynamic_select_out_c_o = active_r[clock_conditioner_pkg::DYN_SEL_C_BIT]; // R02
	assign dynamic_select_out_b_o = active_r[clock_conditioner_pkg::DYN_SEL_B_BIT]; // R02
	assign dynamic_select_out_a_o = active_r[clock_conditioner_pkg::DYN_SEL_A_BIT]; // R02
	assign oscillator_range_select_o =
		active_r[clock_conditioner_pkg::OSC_RANGE_HI:clock_conditioner_pkg::OSC_RANGE_LO]; // R02
	assign static_select_out_c_o = active_r[clock_conditioner_pkg::STAT_SEL_C_BIT]; // R02
	assign static_select_out_b_o = active_r[clock_conditioner_pkg::STAT_SEL_B_BIT]; // R02
	assign static_select_out_a_o = active_r[clock_conditioner_pkg::STAT_SEL_A_BIT]; // R02

	// delay fields
	assign delay_out_c_o = active_r[clock_conditioner_pkg::DELAY_C_LO +: clock_conditioner_pkg::DELAY_WIDTH]; // R03
	assign delay_out_b_o = active_r[clock_conditioner_pkg::DELAY_B_LO +: clock_conditioner_pkg::DELAY_WIDTH]; // R03
	assign global_delay_c_o =
		active_r[clock_conditioner_pkg::GDELAY_C_LO +: clock_conditioner_pkg::DELAY_WIDTH]; // R03
	assign global_delay_b_o =
		active_r[clock_conditioner_pkg::GDELAY_B_LO +: clock_conditioner_pkg::DELAY_WIDTH]; // R03
	assign global_delay_a_o =
		active_r[clock_conditioner_pkg::GDELAY_A_LO +: clock_conditioner_pkg::DELAY_WIDTH]; // R03
	assign extra_delay_select_o = active_r[clock_conditioner_pkg::EXTRA_DELAY_BIT]; // R03
	assign feedback_delay_o =
		active_r[clock_conditioner_pkg::FB_DELAY_LO +: clock_conditioner_pkg::DELAY_WIDTH]; // R03

	// routing fields
	assign feedback_source_select_o =
		active_r[clock_conditioner_pkg::FB_SRC_HI:clock_conditioner_pkg::FB_SRC_LO]; // R04
	assign output_c_route_select_o =
		active_r[clock_conditioner_pkg::ROUTE_C_LO +: clock_conditioner_pkg::ROUTE_WIDTH]; // R04
	assign output_b_route_select_o =
		active_r[clock_conditioner_pkg::ROUTE_B_LO +: clock_conditioner_pkg::ROUTE_WIDTH]; // R04
	assign output_a_route_select_o =
		active_r[clock_conditioner_pkg::ROUTE_A_LO +: clock_conditioner_pkg::ROUTE_WIDTH]; // R04

	// divider fields
	assign output_c_divider_o = active_r[clock_conditioner_pkg::ODIV_C_LO +: clock_conditioner_pkg::ODIV_WIDTH]; // R05
	assign output_b_divider_o = active_r[clock_conditioner_pkg::ODIV_B_LO +: clock_conditioner_pkg::ODIV_WIDTH]; // R05
	assign output_a_divider_o = active_r[clock_conditioner_pkg::ODIV_A_LO +: clock_conditioner_pkg::ODIV_WIDTH]; // R05
	assign feedback_divider_o = active_r[clock_conditioner_pkg::FB_DIV_LO +: clock_conditioner_pkg::DIV7_WIDTH]; // R05
	assign input_divider_o = active_r[clock_conditioner_pkg::IN_DIV_LO +: clock_conditioner_pkg::DIV7_WIDTH]; // R05
endmodule

`default_nettype wire

// ==== clock_conditioner_dynamic_config_chk.sv ====
/*
 * Port-level checker for the clock conditioner dynamic configuration path.
 * Assumes it is bound to the top module and that mclk_i is its only clock.
 */
`timescale 1ns/10ps
`default_nettype none

module clock_conditioner_dynamic_config_chk (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic sclk_i,
	input wire logic supdate_i,
	input wire logic mode_i,
	input wire logic sdout_o,
	input wire logic [80:0] static_config_i,
	input wire logic [80:0] active_config_o,
	input wire logic jtag_tdi_i,
	input wire logic jtag_tdo_o,
	input wire logic fabric_tdi_o,
	input wire logic fabric_tdo_i,
	input wire logic reset_enable_o,
	input wire logic [2:0] oscillator_range_select_o,
	input wire logic static_select_out_a_o,
	input wire logic [4:0] delay_out_c_o,
	input wire logic extra_delay_select_o,
	input wire logic [4:0] feedback_delay_o,
	input wire logic [1:0] feedback_source_select_o,
	input wire logic [2:0] output_a_route_select_o,
	input wire logic [4:0] output_c_divider_o,
	input wire logic [6:0] input_divider_o
);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	// field outputs are fixed slices of the applied settings
	a_top_fields: assert property (reset_enable_o == active_config_o[80] &&
		oscillator_range_select_o == active_config_o[76:74] && static_select_out_a_o == active_config_o[71])
		else $error("top control fields misplaced");
	a_delay_fields: assert property (delay_out_c_o == active_config_o[70:66] &&
		extra_delay_select_o == active_config_o[45] && feedback_delay_o == active_config_o[44:40])
		else $error("delay fields misplaced");
	a_route_fields: assert property (feedback_source_select_o == active_config_o[39:38] &&
		output_a_route_select_o == active_config_o[31:29])
		else $error("route fields misplaced");
	a_divider_fields: assert property (output_c_divider_o == active_config_o[28:24] &&
		input_divider_o == active_config_o[6:0])
		else $error("divider fields misplaced");
	// static switches drive the settings when the dynamic source is off
	a_static_follow: assert property ((!mode_i && rst_b_i)[*5] |-> active_config_o == $past(static_config_i))
		else $error("settings do not follow static switches");
	// dynamic settings move only on an update strobe
	a_update_only: assert property ((mode_i && !supdate_i)[*8] |=> $stable(active_config_o))
		else $error("settings changed without update");
	a_shift_idle: assert property ((!sclk_i)[*6] |=> $stable(sdout_o))
		else $error("serial out moved without shift clock");
	a_tile_tdi: assert property (rst_b_i[*4] |-> fabric_tdi_o == $past(jtag_tdi_i, 3))
		else $error("tile data in not passed to fabric");
	a_tile_tdo: assert property (rst_b_i[*2] |-> jtag_tdo_o == $past(fabric_tdo_i))
		else $error("fabric data not passed to tdo");

	// main scenarios
	c_update: cover property (mode_i && $rose(supdate_i));
	c_shift: cover property ($rose(sclk_i));
	c_mode_back: cover property ($fell(mode_i));
endmodule

bind clock_conditioner_dynamic_config clock_conditioner_dynamic_config_chk clock_conditioner_dynamic_config_chk_i (
	.mclk_i, .rst_b_i, .sclk_i, .supdate_i, .mode_i, .sdout_o, .static_config_i, .active_config_o,
	.jtag_tdi_i, .jtag_tdo_o, .fabric_tdi_o, .fabric_tdo_i, .reset_enable_o, .oscillator_range_select_o,
	.static_select_out_a_o, .delay_out_c_o, .extra_delay_select_o, .feedback_delay_o,
	.feedback_source_select_o, .output_a_route_select_o, .output_c_divider_o, .input_divider_o
);

`default_nettype wire

// ==== clock_conditioner_dynamic_config_test.sv ====
/*
 * Self-checking testbench: static source, dynamic shift and update, refused
 * shifts, shift order and the user jtag tile pass-through.
 * Assumes the package, interface and design files are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module clock_conditioner_dynamic_config_test;
	localparam logic [80:0] PAT_A = 81'h1_2345_6789_ABCD_EF01_2345;
	localparam logic [80:0] PAT_B = 81'h0_F0E1_D2C3_B4A5_9687_7869;
	logic mclk_i, rst_b_i, mode_i, sdin, sclk, sshift, supdate, sdout_o, fabric_tdo_i, jtag_tdo_o;
	logic jtag_tck_i, jtag_tms_i, jtag_tdi_i, jtag_trst_b_i, f_tck, f_tms, f_tdi, f_trst_b;
	logic [80:0] static_config_i, active_config_o, fields_seen, seen;
	logic re, dc, db, da, sc, sb, sa, xd;
	logic [2:0] osc, rc, rb, ra;
	logic [4:0] dlc, dlb, gc, gb, ga, fbd, oc, ob, oa;
	logic [1:0] fbs;
	logic [6:0] feedback_divider, indiv;
	int miscompares = 0;
	int tests_run = 0;

	assign fields_seen = {re, dc, db, da, osc, sc, sb, sa, dlc, dlb, gc, gb, ga, xd, fbd, fbs, rc, rb, ra, oc, ob, oa,
		feedback_divider, indiv};

	clock_conditioner_dynamic_config clock_conditioner_dynamic_config_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.sdin_i(sdin), .sclk_i(sclk), .sshift_i(sshift), .supdate_i(supdate), .mode_i(mode_i), .sdout_o(sdout_o),
		.static_config_i(static_config_i), .jtag_tck_i(jtag_tck_i), .jtag_tms_i(jtag_tms_i),
		.jtag_tdi_i(jtag_tdi_i), .jtag_trst_b_i(jtag_trst_b_i), .jtag_tdo_o(jtag_tdo_o), .fabric_tck_o(f_tck),
		.fabric_tms_o(f_tms), .fabric_tdi_o(f_tdi), .fabric_trst_b_o(f_trst_b), .fabric_tdo_i(fabric_tdo_i),
		.active_config_o(active_config_o), .reset_enable_o(re), .dynamic_select_out_c_o(dc),
		.dynamic_select_out_b_o(db), .dynamic_select_out_a_o(da), .oscillator_range_select_o(osc),
		.static_select_out_c_o(sc), .static_select_out_b_o(sb), .static_select_out_a_o(sa), .delay_out_c_o(dlc),
		.delay_out_b_o(dlb), .global_delay_c_o(gc), .global_delay_b_o(gb), .global_delay_a_o(ga),
		.extra_delay_select_o(xd), .feedback_delay_o(fbd), .feedback_source_select_o(fbs),
		.output_c_route_select_o(rc), .output_b_route_select_o(rb), .output_a_route_select_o(ra),
		.output_c_divider_o(oc), .output_b_divider_o(ob), .output_a_divider_o(oa), .feedback_divider_o(feedback_divider),
		.input_divider_o(indiv));

	fabric_tap_model fabric_tap_model_i (.mclk_i(mclk_i), .sdout_i(sdout_o), .sdin_o(sdin), .sclk_o(sclk),
		.sshift_o(sshift), .supdate_o(supdate));

	// ----------------------------------------------------------------
	// clock, compare and closing tasks
	// ----------------------------------------------------------------
	initial begin
		mclk_i = 1'h0;
		forever #4 mclk_i = ~mclk_i;
	end

	task automatic check(input logic [80:0] seen_v, input logic [80:0] exp_v);
		tests_run++;
		if (seen_v !== exp_v) begin
			miscompares++;
			$display("wrong value at %0t seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge mclk_i);
		miscompares++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_b_i = 1'h0;
		mode_i = 1'h0;
		static_config_i = 81'h0;
		{jtag_tck_i, jtag_tms_i, jtag_tdi_i, jtag_trst_b_i, fabric_tdo_i} = 5'h0;
		repeat (20) @(negedge mclk_i);
		rst_b_i = 1'h1;
		repeat (2) @(negedge mclk_i);
		check(active_config_o, clock_conditioner_pkg::CFG_RESET);
		static_config_i = PAT_A;
		repeat (6) @(negedge mclk_i);
		check(active_config_o, PAT_A);
		check(fields_seen, PAT_A);
		mode_i = 1'h1;
		repeat (6) @(negedge mclk_i);
		check(active_config_o, clock_conditioner_pkg::CFG_RESET);
		fabric_tap_model_i.shift_word(PAT_B, 1'h1, seen);
		check(active_config_o, clock_conditioner_pkg::CFG_RESET);
		fabric_tap_model_i.update();
		check(active_config_o, PAT_B);
		check(fields_seen, PAT_B);
		fabric_tap_model_i.shift_word(PAT_A, 1'h0, seen);
		check(seen, {81{PAT_B[0]}});
		fabric_tap_model_i.update();
		check(active_config_o, PAT_B);
		fabric_tap_model_i.shift_word(PAT_A, 1'h1, seen);
		check(seen, PAT_B);
		fabric_tap_model_i.update();
		check(active_config_o, PAT_A);
		mode_i = 1'h0;
		static_config_i = PAT_B;
		repeat (6) @(negedge mclk_i);
		check(active_config_o, PAT_B);
		for (int k = 0; k < 16; k++) begin
			{jtag_tck_i, jtag_tms_i, jtag_tdi_i, jtag_trst_b_i} = 4'(k);
			fabric_tdo_i = ~jtag_tdi_i;
			repeat (4) @(negedge mclk_i);
			check(81'({f_tck, f_tms, f_tdi, f_trst_b}), 81'(k));
			check(81'(jtag_tdo_o), 81'(fabric_tdo_i));
		end
		stop_test();
	end
endmodule

`default_nettype wire

// ==== clock_conditioner_pkg.sv ====
/*
 * Shared constants for the clock conditioning circuit dynamic configuration path:
 * register width, field positions, pin indices for the synchroniser, reset value.
 * Assumes it is compiled before every other file of the block.
 */
// How it works
// R01: the conditioner takes its settings from static flash switches or from an 81-bit dynamic shift register.
// R02: bit 80 is reset enable, 79..77 dynamic select C/B/A, 76..74 oscillator range, 73..71 static select C/B/A.
// R03: delay fields sit at 70:66, 65:61, 60:56, 55:51, 50:46, bit 45 is extra delay select, 44:40 feedback delay.
// R04: feedback source select is 39:38 and the output route selects C, B, A are 37:35, 34:32, 31:29.
// R05: output dividers C, B, A are 28:24, 23:19, 18:14, feedback divider 13:7 and input divider 6:0.
// R06: the user jtag tile gives fabric two-way access to the jtag port without putting the device in test mode.
// R07: the shift register is reachable from fabric logic that may also connect to the user jtag tile.
// R08: a new stream arriving over jtag can be shifted in through the fabric path and loaded.
// R09: reconfiguration needs no reprogramming and the rest of the device keeps running meanwhile.
// R10: fabric logic acts as its own tap controller, supplying the bits and driving the shift controls.
// R11: all 81 bits are shifted serially and the new settings take effect only on the update strobe.

`default_nettype none

package clock_conditioner_pkg;

	// ----------------------------------------------------------------
	// register geometry
	// ----------------------------------------------------------------
	localparam int CFG_WIDTH = 81;
	localparam logic [80:0] CFG_RESET = 81'h0_0000_0000_0000_0000_0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int RESET_ENABLE_BIT = 80;
	localparam int DYN_SEL_C_BIT = 79;
	localparam int DYN_SEL_B_BIT = 78;
	localparam int DYN_SEL_A_BIT = 77;
	localparam int OSC_RANGE_HI = 76;
	localparam int OSC_RANGE_LO = 74;
	localparam int STAT_SEL_C_BIT = 73;
	localparam int STAT_SEL_B_BIT = 72;
	localparam int STAT_SEL_A_BIT = 71;
	localparam int DELAY_C_LO = 66;
	localparam int DELAY_B_LO = 61;
	localparam int GDELAY_C_LO = 56;
	localparam int GDELAY_B_LO = 51;
	localparam int GDELAY_A_LO = 46;
	localparam int EXTRA_DELAY_BIT = 45;
	localparam int FB_DELAY_LO = 40;
	localparam int DELAY_WIDTH = 5;
	localparam int FB_SRC_HI = 39;
	localparam int FB_SRC_LO = 38;
	localparam int ROUTE_C_LO = 35;
	localparam int ROUTE_B_LO = 32;
	localparam int ROUTE_A_LO = 29;
	localparam int ROUTE_WIDTH = 3;
	localparam int ODIV_C_LO = 24;
	localparam int ODIV_B_LO = 19;
	localparam int ODIV_A_LO = 14;
	localparam int ODIV_WIDTH = 5;
	localparam int FB_DIV_LO = 7;
	localparam int IN_DIV_LO = 0;
	localparam int DIV7_WIDTH = 7;

	// ----------------------------------------------------------------
	// synchroniser pin indices
	// ----------------------------------------------------------------
	localparam int PIN_COUNT = 9;
	localparam int PIN_SDIN = 0;
	localparam int PIN_SCLK = 1;
	localparam int PIN_SSHIFT = 2;
	localparam int PIN_SUPDATE = 3;
	localparam int PIN_MODE = 4;
	localparam int PIN_TCK = 5;
	localparam int PIN_TMS = 6;
	localparam int PIN_TDI = 7;
	localparam int PIN_TRST_B = 8;

endpackage

`default_nettype wire

// ==== fabric_tap_model.sv ====
/*
 * Fabric logic acting as its own tap controller: shifts configuration words
 * serially and strobes the update.
 * Assumes it is called at a falling edge of mclk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module fabric_tap_model (
	input wire logic mclk_i,
	input wire logic sdout_i,
	output logic sdin_o,
	output logic sclk_o,
	output logic sshift_o,
	output logic supdate_o
);
	// ----------------------------------------------------------------
	// idle levels and transfer tasks
	// ----------------------------------------------------------------
	initial begin
		sdin_o = 1'h0;
		sclk_o = 1'h0;
		sshift_o = 1'h0;
		supdate_o = 1'h0;
	end

	// first bit out lands in bit 0; setup, clock high and clock low steps each take four cycles
	task automatic shift_word(input logic [80:0] w, input logic en, output logic [80:0] seen);
		for (int i = 0; i < clock_conditioner_pkg::CFG_WIDTH; i++) begin
			sdin_o = w[i];
			sshift_o = en;
			repeat (4) @(negedge mclk_i);
			seen[i] = sdout_i;
			sclk_o = 1'h1;
			repeat (4) @(negedge mclk_i);
			sclk_o = 1'h0;
			sdin_o = ~w[i]; // data no longer valid
			repeat (4) @(negedge mclk_i);
		end
		sshift_o = 1'h0;
	endtask

	// single update strobe after the whole word
	task automatic update();
		supdate_o = 1'h1;
		repeat (4) @(negedge mclk_i);
		supdate_o = 1'h0;
		repeat (8) @(negedge mclk_i);
	endtask
endmodule

`default_nettype wire

// ==== pin_sync.sv ====
/*
 * Two-flop synchroniser for every asynchronous pin of the block, plus a
 * rising-edge pulse taken from the second stage against a third.
 * Assumes pins are stable for at least three mclk_i periods per level.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic [clock_conditioner_pkg::PIN_COUNT-1:0] pins_i,
	pin_sync_if.producer sync_o
);
	localparam int N = clock_conditioner_pkg::PIN_COUNT;

	logic [N-1:0] meta_r;
	logic [N-1:0] stable_r;
	logic [N-1:0] prev_r;
	logic [N-1:0] meta_nxt;
	logic [N-1:0] stable_nxt;
	logic [N-1:0] prev_nxt;

	// ----------------------------------------------------------------
	// per-pin stages
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_pin
			// first stage read only by the second
			always_comb begin
				meta_nxt[g] = pins_i[g];
				stable_nxt[g] = meta_r[g];
				prev_nxt[g] = stable_r[g];
			end
			assign sync_o.level[g] = stable_r[g];
			assign sync_o.rise[g] = stable_r[g] & ~prev_r[g];
		end
	endgenerate

	// register stages, synchronous reset
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			meta_r <= '0;
			stable_r <= '0;
			prev_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			stable_r <= stable_nxt;
			prev_r <= prev_nxt;
		end
	end
endmodule

`default_nettype wire

// ==== pin_sync_if.sv ====
/*
 * Carries synchronised pin levels and their rising-edge pulses from the
 * synchroniser to the configuration logic.
 * Assumes both ends run on mclk_i.
 */
`timescale 1ns/10ps
`default_nettype none

interface pin_sync_if;
	logic [clock_conditioner_pkg::PIN_COUNT-1:0] level;
	logic [clock_conditioner_pkg::PIN_COUNT-1:0] rise;

	modport producer (output level, output rise);
	modport consumer (input level, input rise);
endinterface

`default_nettype wire
